// ---- hw/cell_alert_consts.vh ----
// constants for the per-cell voltage alert register bank
`ifndef CELL_ALERT_CONSTS_VH
`define CELL_ALERT_CONSTS_VH

// register indices and the byte addresses derived from them
`define IDX_COMBINED        8'h03
`define IDX_OV_FLAGS        8'h04
`define IDX_UV_FLAGS        8'h05
`define IDX_OV_ENABLE       8'h06
`define ADDR_COMBINED       8'h0c
`define ADDR_OV_FLAGS       8'h10
`define ADDR_UV_FLAGS       8'h14
`define ADDR_OV_ENABLE      8'h18
`define ADDR_INT_STATUS     8'h20
`define ADDR_INT_MASK       8'h24
`define ADDR_CELL_BASE      8'h40

// field layout
`define NUM_CELLS           12
`define CELL_MSB            11
`define CELL_SET_OV_BIT     1

// reset values
`define RST_CELL_BITS       12'h000
`define RST_RDATA           32'h00000000

// select codes from the address decoder
`define SEL_NONE            4'h0
`define SEL_COMBINED        4'h1
`define SEL_OV              4'h2
`define SEL_UV              4'h3
`define SEL_EN              4'h4
`define SEL_CELL            4'h5
`define SEL_INT_STATUS      4'h6
`define SEL_INT_MASK        4'h7

// bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

// ---- hw/cell_voltage_alert_registers.v ----
// per-cell voltage alert register bank with an axi4-lite slave
`timescale 1ns/100ps
`include "cell_alert_consts.vh"

module cell_voltage_alert_registers (
  // clock and reset
  input  wire        clock,          // system clock, 40 MHz
  input  wire        rstn,           // synchronous reset, active low

  // cell conditions from the threshold comparators
  input  wire [11:0] ovCondition,    // per-cell overvoltage condition from comparators
  input  wire [11:0] uvCondition,    // per-cell undervoltage condition from comparators

  // write address channel
  input  wire [7:0]  s_axi_awaddr,   // byte address of the write
  input  wire        s_axi_awvalid,  // write address offered
  output reg         s_axi_awready,  // write address taken

  // write data channel
  input  wire [31:0] s_axi_wdata,    // write data, low 12 bits used
  input  wire [3:0]  s_axi_wstrb,    // byte lanes, lanes 2 and 3 ignored
  input  wire        s_axi_wvalid,   // write data offered
  output reg         s_axi_wready,   // write data taken

  // write response channel
  output reg  [1:0]  s_axi_bresp,    // okay or slave error
  output reg         s_axi_bvalid,   // response standing
  input  wire        s_axi_bready,   // response accepted

  // read address channel
  input  wire [7:0]  s_axi_araddr,   // byte address of the read
  input  wire        s_axi_arvalid,  // read address offered
  output reg         s_axi_arready,  // read address taken

  // read data channel
  output reg  [31:0] s_axi_rdata,    // read data, upper bits zero
  output reg  [1:0]  s_axi_rresp,    // okay or slave error
  output reg         s_axi_rvalid,   // read data standing
  input  wire        s_axi_rready,   // read data accepted

  // alarm notification
  output reg         irq             // level, high while an unmasked alarm is pending
);

  // register map, one aligned 32-bit word each:
  //   0x0c  combined alert, overvoltage or undervoltage per cell, read-only
  //   0x10  overvoltage flags, read-only
  //   0x14  undervoltage flags, read-only
  //   0x18  overvoltage notification enables, read-write
  //   0x20  pending overvoltage alarms, write one to clear
  //   0x24  alarm mask for the interrupt output, read-write
  //   0x40  per-cell setting words, one word per cell,
  //         bit 1 is that cell's overvoltage enable
  // bit n of every word below 0x40 belongs to cell n+1; bits 12 and up
  // read zero and drop whatever is written to them.
  // an address outside the map answers with a slave error, a write
  // to a read-only word answers okay and changes nothing.

  // stored state
  reg  [11:0] ovFlag_q;              // overvoltage alert flags
  reg  [11:0] uvFlag_q;              // undervoltage alert flags
  reg  [11:0] ovEnable_q;            // overvoltage notification enables
  reg  [11:0] ovEnable_d;
  reg  [11:0] intStatus_q;           // pending overvoltage alarms, sticky
  wire [11:0] intStatus_d;           // next pending alarms, one assign per cell
  reg  [11:0] intMask_q;             // interrupt mask
  reg  [11:0] intMask_d;
  reg  [7:0]  awAddr_q;              // held write address
  reg         awHeld_q;              // write address taken
  reg  [31:0] wData_q;               // held write data
  reg  [3:0]  wStrb_q;               // held byte strobes
  reg         wHeld_q;               // write data taken

  // write strobe and decode of the held write
  // a held write is carried out once both halves are in and the last
  // response has gone, so the update and bvalid land on the same edge
  wire        doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
  wire [3:0]  wrSel   = regSel(awAddr_q);
  wire [3:0]  wrCell  = cellOf(awAddr_q);
  wire [3:0]  rdSel   = regSel(s_axi_araddr);
  wire [3:0]  rdCell  = cellOf(s_axi_araddr);

  // new overvoltage events: flag about to rise
  // measured against the registered flag, so a standing condition raises one alarm
  wire [11:0] ovRise  = ovCondition & ~ovFlag_q;

  // decode an address into a register select code
  function [3:0] regSel;
    input [7:0] a;
    begin
      // anything off a word boundary is refused
      if (a[1:0] != 2'h0) begin
        regSel = `SEL_NONE;
      // combined alert word
      end else if (a == `ADDR_COMBINED) begin
        regSel = `SEL_COMBINED;
      // overvoltage flags
      end else if (a == `ADDR_OV_FLAGS) begin
        regSel = `SEL_OV;
      // undervoltage flags
      end else if (a == `ADDR_UV_FLAGS) begin
        regSel = `SEL_UV;
      // notification enables
      end else if (a == `ADDR_OV_ENABLE) begin
        regSel = `SEL_EN;
      // pending alarms
      end else if (a == `ADDR_INT_STATUS) begin
        regSel = `SEL_INT_STATUS;
      // alarm mask
      end else if (a == `ADDR_INT_MASK) begin
        regSel = `SEL_INT_MASK;
      // 0x40 to 0x6c: one setting word per cell
      end else if (a[7:6] == 2'h1 && a[5:2] < 4'hc) begin
        regSel = `SEL_CELL;
      // everything else is outside the map
      end else begin
        regSel = `SEL_NONE;
      end
    end
  endfunction

  // cell index of a per-cell setting register address
  // only meaningful once the decoder has chosen a setting word
  function [3:0] cellOf;
    input [7:0] a;
    begin
      cellOf = a[5:2];
    end
  endfunction

  // merge a 16-bit write into a 12-bit field; upper bits dropped
  // lane 0 carries cells 1 to 8, lane 1 cells 9 to 12
  function [11:0] mergeLow;
    input [11:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      mergeLow[7:0]  = s[0] ? d[7:0]  : old[7:0];
      mergeLow[11:8] = s[1] ? d[11:8] : old[11:8];
    end
  endfunction

  // next value of the notification enables, from either access path
  always @* begin
    ovEnable_d = ovEnable_q;
    if (doWrite && wrSel == `SEL_EN) begin
      // whole-word write to the enable register
      ovEnable_d = mergeLow(ovEnable_q, wData_q, wStrb_q);
    end else if (doWrite && wrSel == `SEL_CELL && wStrb_q[0]) begin
      // one bit through that cell's setting word
      ovEnable_d[wrCell] = wData_q[`CELL_SET_OV_BIT];
    end
  end

  // next value of the interrupt mask
  // only the low twelve bits are stored
  always @* begin
    intMask_d = intMask_q;
    if (doWrite && wrSel == `SEL_INT_MASK) begin
      intMask_d = mergeLow(intMask_q, wData_q, wStrb_q);
    end
  end

  // pending alarm per cell: set wins over clear, enable zero clears
  // an event and a write-one-to-clear in one cycle leave the bit set,
  // so a fresh overvoltage is never lost behind a late clear
  genvar g;
  generate
    for (g = 0; g < `NUM_CELLS; g = g + 1) begin : pendCell
      // write one to clear: lane 0 for cells 1 to 8, lane 1 for the rest
      wire clrBit = doWrite && wrSel == `SEL_INT_STATUS &&
                    (g < 8 ? wStrb_q[0] : wStrb_q[1]) && wData_q[g];
      // new event on an enabled cell
      wire setBit = ovRise[g] & ovEnable_d[g];
      // a disabled cell drops its alarm at once, an event raises it,
      // otherwise it holds until a one is written to it
      assign intStatus_d[g] = !ovEnable_d[g] ? 1'b0 :
                              setBit         ? 1'b1 :
                              intStatus_q[g] & ~clrBit;
    end
  endgenerate

  // alert flags track the conditions; host writes never touch them
  // plain copies one cycle late, blind to the enables and the mask
  always @(posedge clock) begin
    if (!rstn) begin
      ovFlag_q <= `RST_CELL_BITS;
      uvFlag_q <= `RST_CELL_BITS;
    end else begin
      ovFlag_q <= ovCondition;
      uvFlag_q <= uvCondition;
    end
  end

  // notification enables, shared by both access paths
  always @(posedge clock) begin
    if (!rstn) begin
      ovEnable_q <= `RST_CELL_BITS;  // all notifications off
    end else begin
      ovEnable_q <= ovEnable_d;
    end
  end

  // pending alarms, sticky until cleared or disabled
  always @(posedge clock) begin
    if (!rstn) begin
      intStatus_q <= `RST_CELL_BITS; // nothing pending
    end else begin
      intStatus_q <= intStatus_d;
    end
  end

  // interrupt mask, separate from the notification enables
  always @(posedge clock) begin
    if (!rstn) begin
      intMask_q <= `RST_CELL_BITS;   // every alarm masked
    end else begin
      intMask_q <= intMask_d;
    end
  end

  // interrupt output from the next state, so it rises with the alarm bit
  always @(posedge clock) begin
    if (!rstn) begin
      irq <= 1'b0;                   // quiet after reset
    end else begin
      irq <= |(intStatus_d & intMask_d);
    end
  end

  // write channels: address and data taken in either order
  // a ready comes back only when nothing is held and no response stands,
  // which keeps a single write in flight
  always @(posedge clock) begin
    if (!rstn) begin
      // nothing held, bus idle
      awAddr_q      <= 8'h00;
      awHeld_q      <= 1'b0;
      wData_q       <= 32'h00000000;
      wStrb_q       <= 4'h0;
      wHeld_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      // address channel
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q      <= s_axi_awaddr;
        awHeld_q      <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!awHeld_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      // data channel
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        wHeld_q      <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!wHeld_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      // response once both halves are held
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // flag registers answer okay but stay unchanged
        s_axi_bresp  <= (wrSel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // response accepted, readies return next cycle
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel: data one cycle after the address is taken
  // reads see the registers as they stood before the taking edge
  always @(posedge clock) begin
    if (!rstn) begin
      // nothing taken, nothing standing
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `RST_RDATA;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= (rdSel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        // upper bits always zero
        case (rdSel)
          // combined alert: either flag per cell
          `SEL_COMBINED: begin
            s_axi_rdata <= {20'h00000, ovFlag_q | uvFlag_q};
          end
          // overvoltage flags as they stand
          `SEL_OV: begin
            s_axi_rdata <= {20'h00000, ovFlag_q};
          end
          // undervoltage flags as they stand
          `SEL_UV: begin
            s_axi_rdata <= {20'h00000, uvFlag_q};
          end
          // notification enables
          `SEL_EN: begin
            s_axi_rdata <= {20'h00000, ovEnable_q};
          end
          // per-cell setting word: enable in bit 1 only
          `SEL_CELL: begin
            s_axi_rdata <= {30'h0, ovEnable_q[rdCell], 1'h0};
          end
          // pending alarms
          `SEL_INT_STATUS: begin
            s_axi_rdata <= {20'h00000, intStatus_q};
          end
          // alarm mask
          `SEL_INT_MASK: begin
            s_axi_rdata <= {20'h00000, intMask_q};
          end
          // unmapped: zero with a slave error
          default: begin
            s_axi_rdata <= `RST_RDATA;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        // data accepted, next address may come
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid && !s_axi_arready) begin
        // first cycle out of reset
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ---- test/cell_alert_host.sv ----
// host model: axi4-lite master for the alert registers
`timescale 1ns/100ps
module cell_alert_host (
  input  wire        clock,
  output reg  [7:0]  s_axi_awaddr,
  output reg         s_axi_awvalid,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata,
  output reg  [3:0]  s_axi_wstrb,
  output reg         s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire        s_axi_bvalid,
  input  wire [1:0]  s_axi_bresp,
  output reg         s_axi_bready,
  output reg  [7:0]  s_axi_araddr,
  output reg         s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire [1:0]  s_axi_rresp,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready
);
  reg aw;  // address still offered
  reg w;   // data still offered
  reg [1:0] bResp;  // last write response
  // idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_wstrb = 4'hf;
    bResp = 2'h0;
  end
  // one write, address and data offered together
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    aw = 1;
    w = 1;
    while (aw || w) begin
      @(posedge clock);
      // each channel released once taken
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    // bready raised only once the response stands, so it is seen waiting
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    bResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // one read, data and response returned
  task rd(input [7:0] a, output [31:0] q, output [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // rready raised only once the data stand, so they are seen held
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ---- test/cell_alert_asserts.sv ----
// bus and field assertions on the register bank ports
`timescale 1ns/100ps
module cell_alert_asserts (
  input wire        clock,
  input wire        rstn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // write address and data taken at one edge
  sequence wTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence rTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_B_LAT: assert property (wTake |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_W_DROP: assert property (wTake |=> !s_axi_awready && !s_axi_wready)
    else $error("write readies stayed high");
  AST_R_LAT: assert property (rTake |=> s_axi_rvalid)
    else $error("read data late");
  AST_AR_DROP: assert property (rTake |=> !s_axi_arready)
    else $error("read ready stayed high");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0)
    else $error("upper read bits not zero");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read data not zero");
endmodule
bind cell_voltage_alert_registers cell_alert_asserts chk_u (
  .clock         (clock),
  .rstn          (rstn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp)
);

// ---- test/tb_top.sv ----
// testbench for the cell voltage alert register bank
`timescale 1ns/100ps
`include "cell_alert_consts.vh"
module tb_top;
  reg         clock;
  reg         rstn;
  reg  [11:0] ovCondition;
  reg  [11:0] uvCondition;
  wire        irq;
  wire [7:0]  s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire        s_axi_rvalid, s_axi_rready;
  integer     miscompares = 0;
  integer     samples_checked = 0;
  reg  [31:0] rdQ;
  reg  [1:0]  rdR;
  cell_voltage_alert_registers dut_u (
    .clock         (clock),
    .rstn          (rstn),
    .ovCondition   (ovCondition),
    .uvCondition   (uvCondition),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .irq           (irq)
  );
  cell_alert_host host_u (
    .clock         (clock),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
  );
  // 40 mhz clock
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  // compare and count
  task chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // read a register and compare its data
  task rc(input [7:0] a, input [31:0] e);
    host_u.rd(a, rdQ, rdR);
    chk("rdata", e, rdQ);
  endtask
  // drive both condition words, let flags land
  task cond(input [11:0] o, input [11:0] u);
    @(posedge clock);
    ovCondition <= o;
    uvCondition <= u;
    repeat (3) @(posedge clock);
  endtask
  // reset values and an unmapped read
  task t_reset;
    rc(`ADDR_OV_FLAGS, 32'h0);
    rc(`ADDR_OV_ENABLE, 32'h0);
    rc(8'h30, 32'h0);
    chk("rresp", 32'h2, {30'h0, rdR});
    host_u.wr(8'h30, 32'hffffffff);
    chk("bresp", `RESP_SLVERR, host_u.bResp);
    $display("t_reset done");
  endtask
  // flags follow conditions: overvoltage at both end cells, undervoltage at cells 2 and 11
  task t_flags;
    cond(12'h801, 12'h402);
    rc(`ADDR_OV_FLAGS, 32'h801);
    rc(`ADDR_UV_FLAGS, 32'h402);
    rc(`ADDR_COMBINED, 32'hc03);
    host_u.wr(`ADDR_OV_FLAGS, 32'hffffffff);
    chk("bresp", `RESP_OKAY, host_u.bResp);
    rc(`ADDR_OV_FLAGS, 32'h801);
    cond(12'h0, 12'h0);
    rc(`ADDR_COMBINED, 32'h0);
    $display("t_flags done");
  endtask
  // enable word and its per-cell alias
  task t_enable;
    host_u.wr(`ADDR_OV_ENABLE, 32'hffffffff);
    chk("bresp", `RESP_OKAY, host_u.bResp);
    rc(`ADDR_OV_ENABLE, 32'hfff);
    rc(`ADDR_CELL_BASE + 8'h2c, 32'h2);
    host_u.wr(`ADDR_CELL_BASE, 32'h0);
    rc(`ADDR_OV_ENABLE, 32'hffe);
    $display("t_enable done");
  endtask
  // alarm set, masked, cleared by enable and by w1c
  task t_alarm;
    host_u.wr(`ADDR_INT_MASK, 32'hfff);
    cond(12'h003, 12'h0);
    rc(`ADDR_INT_STATUS, 32'h2);
    chk("irq", 32'h1, irq);
    host_u.wr(`ADDR_OV_ENABLE, 32'h0);
    rc(`ADDR_INT_STATUS, 32'h0);
    chk("irq", 32'h0, irq);
    rc(`ADDR_OV_FLAGS, 32'h3);
    host_u.wr(`ADDR_OV_ENABLE, 32'h2);
    cond(12'h001, 12'h0);
    cond(12'h003, 12'h0);
    host_u.wr(`ADDR_INT_MASK, 32'h0);
    chk("irq", 32'h0, irq);
    host_u.wr(`ADDR_INT_MASK, 32'hfff);
    chk("irq", 32'h1, irq);
    host_u.wr(`ADDR_INT_STATUS, 32'h2);
    rc(`ADDR_INT_STATUS, 32'h0);
    chk("irq", 32'h0, irq);
    $display("t_alarm done");
  endtask
  // counts and verdict
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    rstn = 0;
    ovCondition = 0;
    uvCondition = 0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    t_flags;
    t_enable;
    t_alarm;
    end_sim;
  end
  // hang guard
  initial begin
    repeat (4000) @(posedge clock);
    miscompares++;
    end_sim;
  end
endmodule
